// file: dv/iadc_i2c_master.sv
// Bus master model for the converter control bench: drives SCL and SDA.
// Assumes SDA is resolved outside with a pull-up; clk paces each phase.
module iadc_i2c_master (
    // Bench clock
    input wire logic clk,
    // Resolved data line
    input wire logic sda,
    // Open-drain drives, 1 = released
    output logic scl_o,
    output logic sda_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // Bus idles released, both lines high
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    // Quarter phase; a phase of 16 clk sits well above the 8 clk floor
    task automatic wait_q;
        repeat (4) @(posedge clk);
    endtask : wait_q

    // START, also a repeated START from low SCL
    task automatic start_c;
        sda_o <= 1'b1;
        repeat (2) wait_q();
        scl_o <= 1'b1;
        repeat (4) wait_q();
        sda_o <= 1'b0;
        repeat (4) wait_q();
        scl_o <= 1'b0;
    endtask : start_c

    task automatic stop_c;
        wait_q();
        sda_o <= 1'b0;
        repeat (3) wait_q();
        scl_o <= 1'b1;
        repeat (4) wait_q();
        sda_o <= 1'b1;
        repeat (4) wait_q();
    endtask : stop_c

    // Data moves a quarter after SCL falls, so no false START or STOP
    task automatic bit_x(input logic b, output logic r);
        wait_q();
        sda_o <= b;
        repeat (3) wait_q();
        scl_o <= 1'b1;
        repeat (4) wait_q();
        r = sda;
        scl_o <= 1'b0;
    endtask : bit_x

    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r);
        end
        bit_x(1'b1, r);
        ack = ~r;
    endtask : wr_byte

    task automatic rd_byte(input logic ack_out, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, r);
            d[i] = r;
        end
        bit_x(~ack_out, r);
    endtask : rd_byte
endmodule : iadc_i2c_master

// file: dv/test_i2c_adc_dac_control.sv
// Self-checking bench for the converter control block.
// Assumes the master model beside it and a comparator modelled here.
module test_i2c_adc_dac_control;
    import iadc_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk = 1'b0;
    logic osc_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] straps;
    logic [7:0] ain [4];
    logic [31:0] lfsr_state = 32'hf4d7_8272;
    int err_count = 0;
    int n_tests = 0;
    logic scl_o, sda_o, sda, sda_out, sda_oe, cmp_above;
    logic [7:0] dac_code, sar_code, prev_res;
    logic analog_output_en, osc_enable;
    iadc_sel_t adc_sel;
    iadc_ctrl_t last_ctrl;
    logic [1:0] ch_exp;
    logic sample_take, sar_active, analog_output_hold;
    int hold_cyc = 0;
    int take_cnt = 0;

    // Periods 40 and 32 ns; the rising edges never coincide
    always #20 clk = ~clk;
    always #16 osc_clk = ~osc_clk;

    // Wired-AND data line; half-step compare so ties read as above
    assign sda = sda_o & (sda_oe ? sda_out : 1'b1);
    assign cmp_above = {ain[adc_sel.chan], 1'b1} > {sar_code, 1'b0};

    iadc_control DUT (.clk(clk), .rst_n(rst_n), .osc_clk(osc_clk),
        .scl_in(scl_o), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .addr_sel_pin_low(straps[0]), .addr_sel_pin_mid(straps[1]),
        .addr_sel_pin_high(straps[2]), .dac_code(dac_code),
        .analog_output_en(analog_output_en), .osc_enable(osc_enable),
        .adc_sel(adc_sel), .sample_take(sample_take),
        .sar_active(sar_active), .analog_output_hold(analog_output_hold),
        .sar_code(sar_code), .cmp_above(cmp_above));

    // Conversion activity per osc cycle; old values read at each edge
    always @(posedge osc_clk) begin
        if (analog_output_hold && sar_active) begin
            hold_cyc++;
        end
        if (sample_take) begin
            take_cnt++;
        end
    end

    iadc_i2c_master m (.clk(clk), .sda(sda), .scl_o(scl_o), .sda_o(sda_o));

    function automatic logic [7:0] rnd();
        lfsr_state = {lfsr_state[30:0], lfsr_state[31] ^ lfsr_state[21]
            ^ lfsr_state[1] ^ lfsr_state[0]};
        return lfsr_state[7:0];
    endfunction : rnd

    function automatic logic [1:0] top_ch(input logic [1:0] cfg);
        if (cfg == CFG_FOUR_SINGLE) return 2'h3;
        return (cfg == CFG_TWO_DIFF) ? 2'h1 : 2'h2;
    endfunction : top_ch

    function automatic logic [1:0] clamp(input logic [1:0] cfg, ch);
        return (ch > top_ch(cfg)) ? top_ch(cfg) : ch;
    endfunction : clamp

    // Differential results: offset binary with the top bit inverted
    function automatic logic [7:0] conv(input logic [1:0] cfg, ch);
        logic d;
        d = cfg == CFG_THREE_DIFF || cfg == CFG_TWO_DIFF
            || (cfg == CFG_MIXED && ch == 2'h2);
        return d ? (ain[ch] ^ 8'h80) : ain[ch];
    endfunction : conv

    task automatic check(input string what, input logic [7:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic sel_dev(input logic rw, output logic ack);
        m.start_c();
        m.wr_byte({ADDR_FIXED, straps, rw}, ack);
        check("addr ack", {7'h0, ack}, 8'h01);
    endtask : sel_dev

    // Control byte, then n DAC bytes each replacing the last
    task automatic wr_ctrl(input logic [7:0] c, input int n);
        logic ack;
        logic [7:0] d;
        sel_dev(1'b0, ack);
        m.wr_byte(c, ack);
        check("ctrl ack", {7'h0, ack}, 8'h01);
        check("out en", {7'h0, analog_output_en}, {7'h0, c[6]});
        for (int k = 0; k < n; k++) begin
            d = rnd();
            m.wr_byte(d, ack);
            check("dac", dac_code, d);
        end
        m.stop_c();
        check("dac hold", dac_code, d);
        last_ctrl = c;
        ch_exp = c[1:0];
    endtask : wr_ctrl

    // Each byte carries the conversion started one trigger earlier
    task automatic rd_seq(input int n);
        logic ack;
        logic [7:0] got, nxt;
        logic [1:0] cfg, cc;
        int h0, s0;
        cfg = last_ctrl.in_cfg;
        h0 = hold_cyc;
        s0 = take_cnt;
        sel_dev(1'b1, ack);
        for (int k = 0; k < n; k++) begin
            cc = clamp(cfg, ch_exp);
            nxt = conv(cfg, cc);
            m.rd_byte(k < n - 1, got);
            check("adc byte", got, prev_res);
            check("chan", {6'h0, adc_sel.chan}, {6'h0, cc});
            check("osc en", {7'h0, osc_enable},
                {7'h0, last_ctrl.out_en});
            prev_res = nxt;
            if (last_ctrl.auto_inc) begin
                ch_exp = (cc == top_ch(cfg)) ? 2'h0 : cc + 2'h1;
            end
        end
        m.stop_c();
        // One sample cycle plus eight settled trials per conversion
        check("hold cyc", 8'(hold_cyc - h0),
            8'(n * (8 * (SETTLE_CYCLES + 1) + 1)));
        check("samples", 8'(take_cnt - s0), 8'(n));
    endtask : rd_seq

    // Hang guard, well past the expected 28k cycles
    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        print_verdict();
    end

    initial begin
        logic ack;
        logic [7:0] r, v;
        prev_res = ADC_POR_RESULT;
        r = rnd();
        straps <= r[2:0];
        for (int i = 0; i < 4; i++) begin
            ain[i] = rnd();
        end
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        check("dac rst", dac_code, DAC_RESET);
        check("en rst", {6'h0, analog_output_en, osc_enable}, 8'h00);
        $display("test reset done");
        m.start_c();
        m.wr_byte({ADDR_FIXED, ~straps, 1'b0}, ack);
        check("strap miss", {7'h0, ack}, 8'h00);
        m.start_c();
        m.wr_byte({4'h8, straps, 1'b1}, ack);
        check("fixed miss", {7'h0, ack}, 8'h00);
        m.stop_c();
        $display("test address done");
        last_ctrl = CTRL_RESET;
        ch_exp = 2'h0;
        rd_seq(2);
        wr_ctrl(8'h40, 3);
        $display("test first read and dac done");
        // Every config, half with auto-increment, random channels;
        // odd passes ask for channel 3 so the clamp is always reached
        for (int t = 0; t < 8; t++) begin
            r = rnd();
            wr_ctrl({1'b0, r[6] | t[2], t[1:0], 1'b0, t[2],
                r[1:0] | {2{t[0]}}}, 1);
            for (int i = 0; i < 4; i++) begin
                v = rnd();
                ain[i] <= v;
            end
            @(posedge clk);
            rd_seq(6);
            $display("test config %0d done", t);
        end
        print_verdict();
    end
endmodule : test_i2c_adc_dac_control

// file: logic/iadc_control.sv
// I2C slave control logic of an 8-bit data acquisition converter.
// Assumes SCL/SDA/strap/comparator pins are asynchronous, SCL slow
// against clk (several clk per phase), osc_clk free-running.
// Summary of operation
// - Answer only an address of fixed part plus three strap pin levels.
// - First byte after START is the address; its last bit sets direction.
// - First byte after address in a write loads the control register.
// - High nibble enables analog output and sets input configuration.
// - Low nibble selects a channel within the current configuration.
// - Auto-increment advances the channel after each finished conversion.
// - A channel absent from the configuration maps to the highest valid one.
// - Auto-increment wraps to channel zero after the highest channel.
// - Reset clears control, disables DAC and oscillator, floats output.
// - Byte after control byte loads DAC data and selects its tap.
// - Output buffer follows enable and holds level until a new DAC byte.
// - Output is held by track-and-hold while the DAC serves conversion.
// - A matching read address starts an A/D conversion.
// - Conversion triggers at SCL fall of the ack before each sent byte.
// - Conversion runs while the previous result shifts out.
// - Differential samples are two's complement, single-ended plain binary.
// - Result lands in ADC data register, then auto-increment selects next.
// - First byte read is the previous result; 80h after reset.
// - Conversion is successive approximation over eight bits.
// - Address bits 3..1 come from the straps; upper nibble is 1001.
// - Address bit 0 is direction: zero write, one read.
// - Receiver acks each byte; reading master nacks the last byte.
module iadc_control
    import iadc_pkg::*;
(
    // System clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Conversion clock
    input wire logic osc_clk,
    // I2C pins, open drain
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Address straps
    input wire logic addr_sel_pin_low,
    input wire logic addr_sel_pin_mid,
    input wire logic addr_sel_pin_high,
    // DAC side
    output logic [7:0] dac_code,
    output logic analog_output_en,
    output logic osc_enable,
    // Conversion side, osc_clk domain except adc_sel
    output iadc_sel_t adc_sel,
    output logic sample_take,
    output logic sar_active,
    output logic analog_output_hold,
    output logic [7:0] sar_code,
    input wire logic cmp_above
);

    // Pin synchronisers; the third stage only feeds edge detection
    logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
    logic [2:0] addr_m, addr_s;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            {scl_m, scl_s, scl_d} <= 3'h7;
            {sda_m, sda_s, sda_d} <= 3'h7;
            addr_m <= 3'h0;
            addr_s <= 3'h0;
        end else begin
            {scl_m, scl_s, scl_d} <= {scl_in, scl_m, scl_s};
            {sda_m, sda_s, sda_d} <= {sda_in, sda_m, sda_s};
            addr_m <= {addr_sel_pin_high, addr_sel_pin_mid, addr_sel_pin_low};
            addr_s <= addr_m;
        end
    end

    // Bus events, seen on synchronised levels
    wire scl_rise = scl_s & ~scl_d;
    wire scl_fall = ~scl_s & scl_d;
    wire bus_start = scl_s & scl_d & sda_d & ~sda_s;
    wire bus_stop = scl_s & scl_d & ~sda_d & sda_s;

    iadc_link_state_t state, next_state;
    logic [7:0] rx_byte, tx_shift, adc_result;
    logic [3:0] bit_cnt;
    logic [1:0] byte_idx;
    logic is_read, master_ack, req_tgl, busy;
    iadc_ctrl_t ctrl;

    // Byte decode
    wire byte_done = (state == ST_RX) && scl_fall &&
                     (bit_cnt == BITS_PER_BYTE);
    wire addr_hit = (rx_byte[7:4] == ADDR_FIXED) &&
                    (rx_byte[3:1] == addr_s);
    wire take_addr = byte_done && (byte_idx == 2'h0);
    wire ctrl_wr = byte_done && (byte_idx == 2'h1) && !is_read;
    wire dac_wr = byte_done && (byte_idx == 2'h2) && !is_read;
    wire trigger = scl_fall && (((state == ST_RX_ACK) && is_read) ||
                   ((state == ST_TX_ACK) && master_ack));

    // Channel clamp and wrap per input configuration
    wire [1:0] max_chan = (ctrl.in_cfg == CFG_FOUR_SINGLE) ? 2'h3 :
                          (ctrl.in_cfg == CFG_TWO_DIFF) ? 2'h1 : 2'h2;
    wire [1:0] eff_chan = (ctrl.chan > max_chan) ? max_chan
                          : ctrl.chan;
    wire [1:0] wrap_chan = (eff_chan == max_chan) ? 2'h0
                           : 2'(eff_chan + 2'h1);
    wire eff_diff = (ctrl.in_cfg == CFG_THREE_DIFF) ||
                    (ctrl.in_cfg == CFG_TWO_DIFF) ||
                    ((ctrl.in_cfg == CFG_MIXED) &&
                     (eff_chan == 2'h2));

    // Link state machine
    always_comb begin
        next_state = state;
        if (bus_start) begin
            next_state = ST_RX;
        end else if (bus_stop) begin
            next_state = ST_IDLE;
        end else begin
            case (state)
                ST_RX: begin
                    if (byte_done) begin
                        next_state = (take_addr && !addr_hit) ? ST_IDLE
                                     : ST_RX_ACK;
                    end
                end
                ST_RX_ACK: begin
                    if (scl_fall) begin
                        next_state = is_read ? ST_TX : ST_RX;
                    end
                end
                ST_TX: begin
                    if (scl_fall && (bit_cnt == LAST_TX_BIT)) begin
                        next_state = ST_TX_ACK;
                    end
                end
                ST_TX_ACK: begin
                    if (scl_fall) begin
                        next_state = master_ack ? ST_TX : ST_IDLE;
                    end
                end
                default: begin
                    next_state = state;
                end
            endcase
        end
    end

    // Bit counter: counts SCL rises when receiving, falls when sending
    wire cnt_clear = bus_start || (scl_fall &&
                     ((state == ST_RX_ACK) || (state == ST_TX_ACK)));
    wire cnt_step = ((state == ST_RX) && scl_rise) ||
                    ((state == ST_TX) && scl_fall);
    wire [3:0] next_bit_cnt = cnt_clear ? 4'h0
                              : cnt_step ? 4'(bit_cnt + 4'h1) : bit_cnt;

    // SDA drive: low for ack, low for zero data bits, released otherwise
    logic next_sda_oe;
    always_comb begin
        next_sda_oe = sda_oe;
        if (bus_start || bus_stop) begin
            next_sda_oe = 1'b0;
        end else if (byte_done) begin
            next_sda_oe = (next_state == ST_RX_ACK);
        end else if (scl_fall && (state == ST_RX_ACK)) begin
            next_sda_oe = is_read && !adc_result[7];
        end else if (scl_fall && (state == ST_TX)) begin
            next_sda_oe = (bit_cnt != LAST_TX_BIT) && !tx_shift[6];
        end else if (scl_fall && (state == ST_TX_ACK)) begin
            next_sda_oe = master_ack && !adc_result[7];
        end
    end
    assign sda_out = 1'b0;

    // Link registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            sda_oe <= 1'b0;
        end else begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            sda_oe <= next_sda_oe;
        end
    end

    // Byte shifting and transfer bookkeeping
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_byte <= 8'h00;
            byte_idx <= 2'h0;
            is_read <= 1'b0;
            master_ack <= 1'b0;
        end else begin
            if ((state == ST_RX) && scl_rise) begin
                rx_byte <= {rx_byte[6:0], sda_s};
            end
            if (bus_start) begin
                byte_idx <= 2'h0;
            end else if (byte_done && (byte_idx != 2'h2)) begin
                byte_idx <= 2'(byte_idx + 2'h1);
            end
            if (take_addr) begin
                is_read <= rx_byte[ADDR_DIR_BIT];
            end
            if ((state == ST_TX_ACK) && scl_rise) begin
                master_ack <= !sda_s;
            end
        end
    end

    // Transmit shifter: holds the older result while a new one converts
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_shift <= ADC_POR_RESULT;
        end else if (trigger) begin
            tx_shift <= adc_result;
        end else if ((state == ST_TX) && scl_fall) begin
            tx_shift <= {tx_shift[6:0], 1'b0};
        end
    end

    // Result crossing back from the conversion domain
    logic done_m, done_s, done_d, done_tgl;
    logic [7:0] sar_result;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            {done_m, done_s, done_d} <= 3'h0;
        end else begin
            {done_m, done_s, done_d} <= {done_tgl, done_m, done_s};
        end
    end
    wire conv_done = done_s ^ done_d;

    // Control, DAC and result registers; a write beats auto-increment
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl <= CTRL_RESET;
            dac_code <= DAC_RESET;
            adc_result <= ADC_POR_RESULT;
        end else begin
            if (ctrl_wr) begin
                ctrl <= rx_byte;
            end else if (conv_done && ctrl.auto_inc) begin
                ctrl.chan <= wrap_chan;
            end
            if (dac_wr) begin
                dac_code <= rx_byte;
            end
            if (conv_done) begin
                adc_result <= sar_result;
            end
        end
    end

    // Request toggle; selection stays frozen while a conversion runs.
    // A trigger that finds the converter busy is dropped, so the bus
    // must allow one conversion time per byte.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            req_tgl <= 1'b0;
            busy <= 1'b0;
            adc_sel <= '0;
        end else if (trigger && !busy) begin
            req_tgl <= !req_tgl;
            busy <= 1'b1;
            adc_sel <= '{diff: eff_diff, chan: eff_chan};
        end else if (conv_done) begin
            busy <= 1'b0;
        end
    end

    // Buffer follows the enable; oscillator runs for it or a conversion
    assign analog_output_en = ctrl.out_en;
    assign osc_enable = ctrl.out_en | busy;

    // Conversion domain: reset, request and comparator synchronisers
    logic ro_m, osc_rst_n, req_m, req_s, req_d, cmp_m, cmp_s;
    always_ff @(posedge osc_clk) begin
        ro_m <= rst_n;
        osc_rst_n <= ro_m;
        cmp_m <= cmp_above;
        cmp_s <= cmp_m;
        if (!osc_rst_n) begin
            {req_m, req_s, req_d} <= 3'h0;
        end else begin
            {req_m, req_s, req_d} <= {req_tgl, req_m, req_s};
        end
    end
    wire new_req = req_s ^ req_d;

    // Successive approximation search
    iadc_sar_state_t sar_st;
    logic [7:0] trial;
    logic [2:0] bit_pos;
    logic [3:0] settle;
    wire [7:0] bit_mask = SAR_UNIT << bit_pos;
    wire [7:0] kept = cmp_s ? trial : (trial & ~bit_mask);
    wire [7:0] coded = adc_sel.diff ? {~kept[7], kept[6:0]}
                       : kept;
    wire decide = (sar_st == SAR_STEP) && (settle == SETTLE_CYCLES);

    always_ff @(posedge osc_clk) begin
        if (!osc_rst_n) begin
            sar_st <= SAR_IDLE;
            trial <= 8'h00;
            bit_pos <= 3'h0;
            settle <= 4'h0;
            sar_result <= ADC_POR_RESULT;
            done_tgl <= 1'b0;
        end else begin
            case (sar_st)
                SAR_IDLE: begin
                    if (new_req) begin
                        sar_st <= SAR_SAMPLE;
                    end
                end
                SAR_SAMPLE: begin
                    sar_st <= SAR_STEP;
                    trial <= SAR_FIRST_TRIAL;
                    bit_pos <= 3'h7;
                    settle <= 4'h0;
                end
                SAR_STEP: begin
                    settle <= decide ? 4'h0 : 4'(settle + 4'h1);
                    if (decide && (bit_pos == 3'h0)) begin
                        sar_result <= coded;
                        done_tgl <= !done_tgl;
                        trial <= kept;
                        sar_st <= SAR_IDLE;
                    end else if (decide) begin
                        trial <= kept | (bit_mask >> 1);
                        bit_pos <= 3'(bit_pos - 3'h1);
                    end
                end
                default: begin
                    sar_st <= SAR_IDLE;
                end
            endcase
        end
    end

    // Analog controls from state flops
    assign sample_take = (sar_st == SAR_SAMPLE);
    assign sar_active = (sar_st != SAR_IDLE);
    assign analog_output_hold = sar_active;
    assign sar_code = trial;

    // Checks, system clock domain
    addr_miss_a: assert property (@(posedge clk) disable iff (!rst_n)
        take_addr && !addr_hit |=> state == ST_IDLE && !sda_oe)
        else $error("unmatched address was acknowledged");
    ack_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
        byte_done && (addr_hit || !take_addr) |=> sda_oe)
        else $error("received byte not acknowledged");
    ctrl_load_a: assert property (@(posedge clk) disable iff (!rst_n)
        ctrl_wr |=> ctrl == $past(rx_byte))
        else $error("control byte not stored");
    dac_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        !dac_wr |=> $stable(dac_code))
        else $error("DAC code changed without a write");
    trig_edge_a: assert property (@(posedge clk) disable iff (!rst_n)
        trigger |-> scl_fall ##1 tx_shift == $past(adc_result))
        else $error("trigger off ack fall or wrong byte loaded");
    por_values_a: assert property (@(posedge clk)
        !rst_n |=> ctrl == CTRL_RESET && adc_result == ADC_POR_RESULT
        && !osc_enable)
        else $error("reset values wrong");
    chan_clamp_a: assert property (@(posedge clk) disable iff (!rst_n)
        trigger && !busy |=> adc_sel.chan <= max_chan)
        else $error("absent channel selected");
    auto_inc_a: assert property (@(posedge clk) disable iff (!rst_n)
        conv_done && ctrl.auto_inc && !ctrl_wr |=>
        ctrl.chan == $past(wrap_chan))
        else $error("channel not advanced after conversion");
    read_start_a: assert property (@(posedge clk) disable iff (!rst_n)
        trigger && !busy |=> busy ##1 osc_enable)
        else $error("read trigger did not start conversion");

    // Checks, conversion clock domain
    sar_bound_a: assert property (@(posedge osc_clk)
        disable iff (!osc_rst_n)
        $rose(sar_active) |-> ##[30:40] !sar_active)
        else $error("conversion length wrong");
    diff_code_a: assert property (@(posedge osc_clk)
        disable iff (!osc_rst_n)
        decide && bit_pos == 3'h0 |=>
        sar_result[7] == (adc_sel.diff ^ $past(kept[7])))
        else $error("output coding wrong for input mode");

    // Main scenarios
    ctrl_write_c: cover property (@(posedge clk) disable iff (!rst_n)
        ctrl_wr ##[1:400] dac_wr);
    read_burst_c: cover property (@(posedge clk) disable iff (!rst_n)
        trigger ##[1:800] trigger);
    chan_wrap_c: cover property (@(posedge clk) disable iff (!rst_n)
        conv_done && ctrl.auto_inc && eff_chan == max_chan);
    sar_done_c: cover property (@(posedge osc_clk)
        disable iff (!osc_rst_n) decide && bit_pos == 3'h0);

endmodule : iadc_control

// file: pkg/iadc_pkg.sv
// Shared constants and types for the converter control block.
// Assumes one I2C-side clock domain and one conversion-clock domain.
package iadc_pkg;

    // Slave address layout
    localparam logic [3:0] ADDR_FIXED = 4'h9;
    localparam int ADDR_DIR_BIT = 0;

    // Reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] DAC_RESET = 8'h00;
    localparam logic [7:0] ADC_POR_RESULT = 8'h80;

    // Byte framing and conversion sequencing
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_TX_BIT = 4'h7;
    localparam logic [7:0] SAR_FIRST_TRIAL = 8'h80;
    localparam logic [7:0] SAR_UNIT = 8'h01;
    // Comparator synchroniser depth plus one cycle of settling
    localparam logic [3:0] SETTLE_CYCLES = 4'h3;

    // Input configurations held in the control byte
    localparam logic [1:0] CFG_FOUR_SINGLE = 2'h0;
    localparam logic [1:0] CFG_THREE_DIFF = 2'h1;
    localparam logic [1:0] CFG_MIXED = 2'h2;
    localparam logic [1:0] CFG_TWO_DIFF = 2'h3;

    // Control register fields, bit 7 down to bit 0
    typedef struct packed {
        logic rsv_hi;
        logic out_en;
        logic [1:0] in_cfg;
        logic rsv_lo;
        logic auto_inc;
        logic [1:0] chan;
    } iadc_ctrl_t;

    // Channel selection handed to the analog input multiplexer
    typedef struct packed {
        logic diff;
        logic [1:0] chan;
    } iadc_sel_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RX = 5'h02,
        ST_RX_ACK = 5'h04,
        ST_TX = 5'h08,
        ST_TX_ACK = 5'h10
    } iadc_link_state_t;

    typedef enum logic [2:0] {
        SAR_IDLE = 3'h1,
        SAR_SAMPLE = 3'h2,
        SAR_STEP = 3'h4
    } iadc_sar_state_t;

endpackage : iadc_pkg
